// ==== tb/mpsc_gated_model.sv ====
/*
  Far-side model of the clock-gated modules: reports idle per slot.
  Assumes clock enables and stop requests come on the same clock.
*/
module mpsc_gated_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Behaviour select
  input  wire logic        slow,
  // Controller side
  input  wire logic [39:0] clk_en,
  input  wire logic [39:0] stop_req,
  output logic      [39:0] idle_r
);
  // --------------------------------------------------------------------------
  // Idle report
  // --------------------------------------------------------------------------
  // Slow modules never finish, so the controller must fall back on its timeout
  always_ff @(posedge clock) begin
    if (rst) begin
      idle_r <= '1;
    end else begin
      idle_r <= ~clk_en | (stop_req & {40{~slow}});
    end
  end
endmodule : mpsc_gated_model

// ==== tb/mpsc_power_sleep_ctrl_monitor.sv ====
/*
  Concurrent checks of the power and sleep controller, bound to its top module.
  Assumes one clock domain with a synchronous active-high reset.
*/
`include "mpsc_defines.svh"

module mpsc_power_sleep_ctrl_monitor
  import mpsc_pkg::*;
#(
  parameter bit [`MPSC_NUM_SLOTS-1:0] RSVD_MASK        = `MPSC_RSVD_SINGLE_CORE,
  parameter int                       IO_GROUPS        = 8,
  parameter int                       STOP_TIMEOUT_CYC = `MPSC_STOP_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic                        clock,
  input wire logic                        rst,
  // Slot control
  input wire logic                        slot_wr,
  input wire mpsc_pkg::mpsc_slot_idx_t    slot_wr_idx,
  input wire logic                        slot_wr_enable,
  input wire logic [`MPSC_NUM_SLOTS-1:0]  module_clk_en_r,
  input wire logic [`MPSC_NUM_SLOTS-1:0]  module_stop_req_r,
  input wire logic                        dsp_core_clk_en_r,
  input wire logic                        ethernet_mac_mem_clk_en_r,
  input wire logic                        ddr_ctrl_clk_en_r,
  // Registers
  input wire logic                        io_group_wr,
  input wire logic [IO_GROUPS-1:0]        io_group_wdata,
  input wire logic [IO_GROUPS-1:0]        io_group_powerdown_r,
  input wire logic                        pll_ctl_wr,
  input wire logic                        pll_ctl_osc_en,
  input wire logic                        pll_ctl_pll_en,
  input wire logic [`MPSC_PLL_MULT_W-1:0] pll_ctl_mult,
  input wire logic                        osc_en_r,
  input wire logic                        pll_en_r,
  input wire logic [`MPSC_PLL_MULT_W-1:0] pll_mult_r,
  // Core power
  input wire logic                        core_idle_instr,
  input wire logic                        core_wake,
  input wire logic                        dsp_core_sleep_r,
  input wire logic                        dsp_subsystem_power_on_r
);
  // Timeout plus the port latency of the gate
  localparam int STOP_MAX = STOP_TIMEOUT_CYC + 4;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // --------------------------------------------------------------------------
  // Slot gating
  // --------------------------------------------------------------------------
  sequence s_on_req5;
    slot_wr && slot_wr_enable && slot_wr_idx == 6'h05 && !module_clk_en_r[5] && !module_stop_req_r[5];
  endsequence
  sequence s_gate_open5;
    ##2 !module_clk_en_r[5] ##1 module_clk_en_r[5];
  endsequence

  chk_on_latency: assert property (s_on_req5 |-> s_gate_open5)
    else $error("late open");
  chk_rsvd_gate_off: assert property ((module_clk_en_r & RSVD_MASK) == '0)
    else $error("reserved on");
  chk_slot_copies: assert property ({dsp_core_clk_en_r, ethernet_mac_mem_clk_en_r, ddr_ctrl_clk_en_r} == {module_clk_en_r[39], module_clk_en_r[6], module_clk_en_r[13]})
    else $error("copy differs");
  chk_stop_bound: assert property ($rose(module_stop_req_r[13]) |-> ##[1:STOP_MAX] !module_clk_en_r[13])
    else $error("stop late");

  // --------------------------------------------------------------------------
  // Registers and core power
  // --------------------------------------------------------------------------
  chk_io_group_wr: assert property (io_group_wr |=> io_group_powerdown_r == $past(io_group_wdata))
    else $error("io write");
  chk_pll_write: assert property (pll_ctl_wr |=> osc_en_r == $past(pll_ctl_osc_en) && pll_en_r == $past(pll_ctl_pll_en) && pll_mult_r == $past(pll_ctl_mult))
    else $error("pll write");
  chk_reset_clock: assert property ($fell(rst) |-> osc_en_r && !pll_en_r && pll_mult_r == 5'h00)
    else $error("reset clock");
  chk_core_sleep: assert property (core_idle_instr && !core_wake && dsp_subsystem_power_on_r |=> dsp_core_sleep_r)
    else $error("no sleep");
  chk_core_wake: assert property (core_wake |=> !dsp_core_sleep_r)
    else $error("no wake");
endmodule : mpsc_power_sleep_ctrl_monitor

bind mpsc_power_sleep_ctrl mpsc_power_sleep_ctrl_monitor #(
  .RSVD_MASK(RSVD_MASK), .IO_GROUPS(IO_GROUPS), .STOP_TIMEOUT_CYC(STOP_TIMEOUT_CYC)
) u_monitor (.*);

// ==== tb/tb_top.sv ====
/*
  Self-checking bench of the power and sleep controller.
  Assumes the design and monitor are compiled first; inputs change at falling edges.
*/
`include "mpsc_defines.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mpsc_pkg::*;

  localparam bit [39:0] RSVD = `MPSC_RSVD_SINGLE_CORE;

  logic             clock = 1'b0;
  logic             rst   = 1'b1;
  logic             slot_wr, slot_wr_enable, slow, io_group_wr, pll_ctl_wr, pll_ctl_osc_en, pll_ctl_pll_en;
  logic             video_encoder_mode_wr, video_encoder_mode_enable, dac_test_wr, core_idle_instr, core_wake, core_mem_wr;
  logic             chip_sw_wr, chip_sw_dsp_power_on, slot_rd_enable_r, slot_busy_r, osc_en_r, pll_en_r;
  logic             dsp_core_clk_en_r, ethernet_mac_mem_clk_en_r, ddr_ctrl_clk_en_r, dsp_core_sleep_r;
  logic             dsp_subsystem_power_on_r;
  mpsc_slot_idx_t   slot_wr_idx, slot_rd_idx;
  mpsc_slot_state_e slot_rd_state_r;
  logic [39:0]      module_idle, module_clk_en_r, module_stop_req_r, exp_en;
  logic [7:0]       io_group_wdata, io_group_powerdown_r;
  logic [4:0]       pll_ctl_mult, pll_mult_r;
  logic [3:0]       dac_test_pwdn, video_dac_en_r;
  logic [2:0]       core_mem_sleep, dsp_mem_sleep_r;
  int               error_cnt, total_checks, cyc;

  always #10 clock = ~clock;

  mpsc_power_sleep_ctrl #(.RSVD_MASK(RSVD), .SETTLE_CYC(1), .STOP_TIMEOUT_CYC(4)) DUT (
    .clock(clock), .rst(rst), .slot_wr(slot_wr), .slot_wr_idx(slot_wr_idx), .slot_wr_enable(slot_wr_enable),
    .slot_rd_idx(slot_rd_idx), .slot_rd_enable_r(slot_rd_enable_r), .slot_rd_state_r(slot_rd_state_r),
    .slot_busy_r(slot_busy_r), .module_idle(module_idle), .module_clk_en_r(module_clk_en_r),
    .module_stop_req_r(module_stop_req_r), .dsp_core_clk_en_r(dsp_core_clk_en_r),
    .ethernet_mac_mem_clk_en_r(ethernet_mac_mem_clk_en_r), .ddr_ctrl_clk_en_r(ddr_ctrl_clk_en_r), .io_group_wr(io_group_wr),
    .io_group_wdata(io_group_wdata), .io_group_powerdown_r(io_group_powerdown_r), .pll_ctl_wr(pll_ctl_wr),
    .pll_ctl_osc_en(pll_ctl_osc_en), .pll_ctl_pll_en(pll_ctl_pll_en), .pll_ctl_mult(pll_ctl_mult),
    .osc_en_r(osc_en_r), .pll_en_r(pll_en_r), .pll_mult_r(pll_mult_r), .video_encoder_mode_wr(video_encoder_mode_wr),
    .video_encoder_mode_enable(video_encoder_mode_enable), .dac_test_wr(dac_test_wr), .dac_test_pwdn(dac_test_pwdn),
    .video_dac_en_r(video_dac_en_r), .core_idle_instr(core_idle_instr), .core_wake(core_wake),
    .core_mem_wr(core_mem_wr), .core_mem_sleep(core_mem_sleep), .dsp_core_sleep_r(dsp_core_sleep_r),
    .dsp_mem_sleep_r(dsp_mem_sleep_r), .chip_sw_wr(chip_sw_wr), .chip_sw_dsp_power_on(chip_sw_dsp_power_on),
    .dsp_subsystem_power_on_r(dsp_subsystem_power_on_r)
  );

  mpsc_gated_model u_far (
    .clock(clock), .rst(rst), .slow(slow), .clk_en(module_clk_en_r), .stop_req(module_stop_req_r),
    .idle_r(module_idle)
  );

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic check(input logic [39:0] got, input logic [39:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : wait_cyc

  task automatic slot_write(input int idx, input logic en);
    @(negedge clock);
    slot_wr        = 1'b1;
    slot_wr_idx    = 6'(idx);
    slot_wr_enable = en;
    @(negedge clock);
    slot_wr = 1'b0;
  endtask : slot_write

  // One-cycle strobe, then time for the two-stage video path to land
  task automatic strobe(input int which);
    @(negedge clock);
    case (which)
      0: io_group_wr = 1'b1;
      1: pll_ctl_wr = 1'b1;
      2: video_encoder_mode_wr = 1'b1;
      3: dac_test_wr = 1'b1;
      4: core_idle_instr = 1'b1;
      5: core_wake = 1'b1;
      6: core_mem_wr = 1'b1;
      default: chip_sw_wr = 1'b1;
    endcase
    @(negedge clock);
    {io_group_wr, pll_ctl_wr, video_encoder_mode_wr, dac_test_wr, core_idle_instr, core_wake, core_mem_wr, chip_sw_wr} = '0;
    wait_cyc(2);
  endtask : strobe

  task automatic wait_off(input int idx);
    int n;
    n = 0;
    while (module_clk_en_r[idx] !== 1'b0 && n < 30) begin
      @(negedge clock);
      n++;
    end
  endtask : wait_off

  task automatic results();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      $display("ERROR %0t: run did not finish", $time);
      results();
    end
  end

  // --------------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------------
  initial begin
    {slot_wr, slot_wr_enable, slow, io_group_wr, pll_ctl_wr, pll_ctl_pll_en, pll_ctl_osc_en} = '0;
    {video_encoder_mode_wr, video_encoder_mode_enable, dac_test_wr, core_idle_instr, core_wake, core_mem_wr, chip_sw_wr} = '0;
    {slot_wr_idx, slot_rd_idx, io_group_wdata, pll_ctl_mult, core_mem_sleep} = '0;
    dac_test_pwdn        = 4'hf;
    chip_sw_dsp_power_on = 1'b1;
    wait_cyc(20);
    rst = 1'b0;
    @(negedge clock);
    check(40'({osc_en_r, pll_en_r, pll_mult_r}), 40'h40, "clock mode at reset");
    check(40'({io_group_powerdown_r, video_dac_en_r, dsp_core_sleep_r, dsp_mem_sleep_r, dsp_subsystem_power_on_r}),
          40'h1, "power state at reset");
    check(module_clk_en_r, 40'h0, "gates at reset");
    // Every slot number, reserved and out of range included
    for (int i = 0; i < 64; i++) slot_write(i, 1'b1);
    wait_cyc(8);
    exp_en = ~RSVD;
    check(module_clk_en_r, exp_en, "all slots on");
    check(40'(dsp_core_clk_en_r), 40'h1, "core gate");
    check(40'(ethernet_mac_mem_clk_en_r), 40'h1, "mac memory gate");
    check(40'(ddr_ctrl_clk_en_r), 40'h1, "sdram gate");
    slot_rd_idx = 6'd39;
    wait_cyc(2);
    check(40'({slot_rd_enable_r, slot_rd_state_r, slot_busy_r}), 40'hc, "slot 39");
    slot_rd_idx = 6'd10;
    wait_cyc(2);
    check(40'({slot_rd_enable_r, slot_rd_state_r}), 40'h0, "reserved slot read");
    slot_write(6, 1'b0);
    wait_off(6);
    exp_en[6] = 1'b0;
    check(module_clk_en_r, exp_en, "only slot 6 off");
    slow = 1'b1;
    slot_write(13, 1'b0);
    wait_off(13);
    slow      = 1'b0;
    exp_en[13] = 1'b0;
    check(module_clk_en_r, exp_en, "slot 13 off by timeout");
    check(40'(ddr_ctrl_clk_en_r), 40'h0, "sdram gate off");
    io_group_wdata = 8'ha5;
    strobe(0);
    check(40'(io_group_powerdown_r), 40'ha5, "io groups");
    check(module_clk_en_r, exp_en, "gates after io write");
    {pll_ctl_osc_en, pll_ctl_pll_en, pll_ctl_mult} = 7'h2a;
    strobe(1);
    check(40'({osc_en_r, pll_en_r, pll_mult_r}), 40'h2a, "pll control");
    video_encoder_mode_enable = 1'b1;
    strobe(2);
    check(40'(video_dac_en_r), 40'h0, "dacs off");
    dac_test_pwdn = 4'h5;
    strobe(3);
    check(40'(video_dac_en_r), 40'ha, "dacs enabled");
    video_encoder_mode_enable = 1'b0;
    strobe(2);
    check(40'(video_dac_en_r), 40'h0, "encoder off");
    strobe(4);
    check(40'(dsp_core_sleep_r), 40'h1, "core asleep");
    core_mem_sleep = 3'h5;
    strobe(6);
    check(40'(dsp_mem_sleep_r), 40'h5, "memories asleep");
    strobe(5);
    check(40'(dsp_core_sleep_r), 40'h0, "core awake");
    chip_sw_dsp_power_on = 1'b0;
    strobe(7);
    check(40'(dsp_subsystem_power_on_r), 40'h1, "dsp stays on");
    rst = 1'b1;
    wait_cyc(2);
    rst = 1'b0;
    @(negedge clock);
    check(40'({osc_en_r, pll_en_r, pll_mult_r}), 40'h40, "reset 2 clk");
    check(module_clk_en_r, 40'h0, "reset 2 gates");
    results();
  end
endmodule : tb_top

// ==== verilog/mpsc_defines.svh ====
/*
  Constants of the module power and sleep controller: slot numbers, reserved
  slot maps, reset values and timing counts.
  Assumes a single 50 MHz clock and inclusion by bare name.
*/
`ifndef MPSC_DEFINES_SVH
`define MPSC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Slots
// ----------------------------------------------------------------------------
`define MPSC_NUM_SLOTS        40
`define MPSC_SLOT_W           6
`define MPSC_SLOT_ETHERNET_MAC_MEM    6'h06
`define MPSC_SLOT_DDR         6'h0d
`define MPSC_SLOT_DSP_CORE    6'h27
// Bit set means the slot number controls no module
`define MPSC_RSVD_SINGLE_CORE 40'h7f_e020_0400
`define MPSC_RSVD_DUAL_CORE   40'h7f_e001_0100

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define MPSC_PLL_MULT_W       5
`define MPSC_PLL_MULT_X1      5'h00
`define MPSC_OSC_EN_RST       1'b1
`define MPSC_PLL_EN_RST       1'b0
`define MPSC_DSP_PWR_ON_RST   1'b1

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define MPSC_CLK_PERIOD_NS    20
`define MPSC_SETTLE_NS        100
`define MPSC_STOP_TIMEOUT_NS  2000
// Least time rounds up, longest time rounds down
`define MPSC_SETTLE_CYC       ((`MPSC_SETTLE_NS + `MPSC_CLK_PERIOD_NS - 1) / `MPSC_CLK_PERIOD_NS)
`define MPSC_STOP_TIMEOUT_CYC (`MPSC_STOP_TIMEOUT_NS / `MPSC_CLK_PERIOD_NS)

`endif

// ==== verilog/mpsc_local_clk_ctrl.sv ====
/*
  Local module clock controller: one per slot, with its own state machine.
  Assumes the gated module reports idle on the same clock.
*/
`include "mpsc_defines.svh"

module mpsc_local_clk_ctrl #(
  parameter int SETTLE_CYC       = `MPSC_SETTLE_CYC,
  parameter int STOP_TIMEOUT_CYC = `MPSC_STOP_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst,
  // Control
  input  wire logic                      present,
  input  wire logic                      enable_req,
  // Gated module
  input  wire logic                      module_idle,
  output logic                           clk_en_r,
  output logic                           stop_req_r,
  output mpsc_pkg::mpsc_slot_state_e     state_r
);
  import mpsc_pkg::*;

  localparam int CNT_W = $clog2(STOP_TIMEOUT_CYC + 1);

  initial begin
    if (SETTLE_CYC < 1 || STOP_TIMEOUT_CYC < SETTLE_CYC)
      $error("mpsc_local_clk_ctrl: bad timing parameters");
  end

  logic [CNT_W-1:0] cnt_r;

  // --------------------------------------------------------------------------
  // State machine
  // --------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r    <= MPSC_SLOT_OFF;
      clk_en_r   <= 1'b0;
      stop_req_r <= 1'b0;
      cnt_r      <= '0;
    end else begin
      unique case (state_r)
        MPSC_SLOT_OFF: begin
          if (present && enable_req) begin
            state_r  <= MPSC_SLOT_STARTING;
            clk_en_r <= 1'b1;
            cnt_r    <= CNT_W'(SETTLE_CYC - 1);
          end
        end
        MPSC_SLOT_STARTING: begin
          // Module gets its clock a settle time before it counts as on
          if (cnt_r == '0) state_r <= MPSC_SLOT_ON;
          else cnt_r <= cnt_r - 1'b1;
        end
        MPSC_SLOT_ON: begin
          if (!enable_req) begin
            state_r    <= MPSC_SLOT_STOPPING;
            stop_req_r <= 1'b1;
            cnt_r      <= CNT_W'(STOP_TIMEOUT_CYC - 1);
          end
        end
        MPSC_SLOT_STOPPING: begin
          // A module that never reports idle is gated after the timeout
          if (module_idle || cnt_r == '0) begin
            state_r    <= MPSC_SLOT_OFF;
            clk_en_r   <= 1'b0;
            stop_req_r <= 1'b0;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
      endcase
    end
  end

endmodule : mpsc_local_clk_ctrl

// ==== verilog/mpsc_pkg.sv ====
/*
  Types of the module power and sleep controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mpsc_pkg;

  // --------------------------------------------------------------------------
  // Per-slot clock state
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MPSC_SLOT_OFF      = 2'b00,
    MPSC_SLOT_STARTING = 2'b01,
    MPSC_SLOT_ON       = 2'b10,
    MPSC_SLOT_STOPPING = 2'b11
  } mpsc_slot_state_e;

  typedef logic [5:0] mpsc_slot_idx_t;

endpackage : mpsc_pkg

// ==== verilog/mpsc_power_sleep_ctrl.sv ====
/*
  Global power and sleep controller: per-slot enable registers, one local
  clock controller per slot, IO group power, oscillator and PLL control,
  video DAC enables, DSP core and memory sleep, DSP subsystem power.
  Assumes software writes arrive as one-cycle strobes on the same clock and
  that gated modules and the DSP core are logic on the same clock.
*/
`include "mpsc_defines.svh"

module mpsc_power_sleep_ctrl #(
  parameter bit [`MPSC_NUM_SLOTS-1:0] RSVD_MASK        = `MPSC_RSVD_SINGLE_CORE,
  parameter bit                       DUAL_CORE        = 1'b0,
  parameter int                       IO_GROUPS        = 8,
  parameter int                       VIDEO_DACS       = 4,
  parameter int                       DSP_MEMS         = 3,
  parameter int                       SETTLE_CYC       = `MPSC_SETTLE_CYC,
  parameter int                       STOP_TIMEOUT_CYC = `MPSC_STOP_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic                                clock,
  input  wire logic                                rst,
  // Slot enable write
  input  wire logic                                slot_wr,
  input  wire mpsc_pkg::mpsc_slot_idx_t            slot_wr_idx,
  input  wire logic                                slot_wr_enable,
  // Slot status read
  input  wire mpsc_pkg::mpsc_slot_idx_t            slot_rd_idx,
  output logic                                     slot_rd_enable_r,
  output mpsc_pkg::mpsc_slot_state_e               slot_rd_state_r,
  output logic                                     slot_busy_r,
  // Gated modules
  input  wire logic [`MPSC_NUM_SLOTS-1:0]          module_idle,
  output logic [`MPSC_NUM_SLOTS-1:0]               module_clk_en_r,
  output logic [`MPSC_NUM_SLOTS-1:0]               module_stop_req_r,
  output logic                                     dsp_core_clk_en_r,
  output logic                                     ethernet_mac_mem_clk_en_r,
  output logic                                     ddr_ctrl_clk_en_r,
  // IO group power-down register
  input  wire logic                                io_group_wr,
  input  wire logic [IO_GROUPS-1:0]                io_group_wdata,
  output logic [IO_GROUPS-1:0]                     io_group_powerdown_r,
  // PLL control register
  input  wire logic                                pll_ctl_wr,
  input  wire logic                                pll_ctl_osc_en,
  input  wire logic                                pll_ctl_pll_en,
  input  wire logic [`MPSC_PLL_MULT_W-1:0]         pll_ctl_mult,
  output logic                                     osc_en_r,
  output logic                                     pll_en_r,
  output logic [`MPSC_PLL_MULT_W-1:0]              pll_mult_r,
  // Video encoder mode and DAC test registers
  input  wire logic                                video_encoder_mode_wr,
  input  wire logic                                video_encoder_mode_enable,
  input  wire logic                                dac_test_wr,
  input  wire logic [VIDEO_DACS-1:0]               dac_test_pwdn,
  output logic [VIDEO_DACS-1:0]                    video_dac_en_r,
  // DSP core power
  input  wire logic                                core_idle_instr,
  input  wire logic                                core_wake,
  input  wire logic                                core_mem_wr,
  input  wire logic [DSP_MEMS-1:0]                 core_mem_sleep,
  output logic                                     dsp_core_sleep_r,
  output logic [DSP_MEMS-1:0]                      dsp_mem_sleep_r,
  // Chip short switch register
  input  wire logic                                chip_sw_wr,
  input  wire logic                                chip_sw_dsp_power_on,
  output logic                                     dsp_subsystem_power_on_r
);
  import mpsc_pkg::*;

  localparam int NS = `MPSC_NUM_SLOTS;

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  initial begin
    if (RSVD_MASK[`MPSC_SLOT_DSP_CORE] || RSVD_MASK[`MPSC_SLOT_ETHERNET_MAC_MEM] || RSVD_MASK[`MPSC_SLOT_DDR])
      $error("mpsc_power_sleep_ctrl: a fixed slot is marked reserved");
    if (IO_GROUPS < 1 || VIDEO_DACS < 1 || DSP_MEMS < 1)
      $error("mpsc_power_sleep_ctrl: group counts must be at least one");
    if (SETTLE_CYC < 1 || STOP_TIMEOUT_CYC < SETTLE_CYC)
      $error("mpsc_power_sleep_ctrl: bad timing parameters");
  end

  // --------------------------------------------------------------------------
  // Slot enable registers
  // --------------------------------------------------------------------------
  logic [NS-1:0]    slot_enable_r;
  mpsc_slot_state_e slot_state [NS];
  logic [NS-1:0]    slot_clk_en;
  logic [NS-1:0]    slot_stop_req;
  logic             wr_valid;

  // Out-of-range indices are treated like reserved slots
  assign wr_valid = slot_wr && (slot_wr_idx < 6'(NS)) && !RSVD_MASK[slot_wr_idx];

  always_ff @(posedge clock) begin
    if (rst) begin
      slot_enable_r <= '0;
    end else if (wr_valid) begin
      slot_enable_r[slot_wr_idx] <= slot_wr_enable;
    end
  end

  // --------------------------------------------------------------------------
  // Local clock controllers
  // --------------------------------------------------------------------------
  // Reserved slots get an instance too, but it is held off by present=0 so
  // it never raises its clock; synthesis trims the dead state.
  for (genvar s = 0; s < NS; s++) begin : g_slot
    mpsc_local_clk_ctrl #(
      .SETTLE_CYC       (SETTLE_CYC),
      .STOP_TIMEOUT_CYC (STOP_TIMEOUT_CYC)
    ) u_slot (
      .clock       (clock),
      .rst         (rst),
      .present     (!RSVD_MASK[s]),
      .enable_req  (slot_enable_r[s]),
      .module_idle (module_idle[s]),
      .clk_en_r    (slot_clk_en[s]),
      .stop_req_r  (slot_stop_req[s]),
      .state_r     (slot_state[s])
    );
  end

  // Registered copies keep every module clock enable a flop output
  always_ff @(posedge clock) begin
    if (rst) begin
      module_clk_en_r   <= '0;
      module_stop_req_r <= '0;
    end else begin
      module_clk_en_r   <= slot_clk_en & ~RSVD_MASK;
      module_stop_req_r <= slot_stop_req & ~RSVD_MASK;
    end
  end

  // --------------------------------------------------------------------------
  // Fixed-slot enables
  // --------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      dsp_core_clk_en_r <= 1'b0;
      ethernet_mac_mem_clk_en_r <= 1'b0;
      ddr_ctrl_clk_en_r <= 1'b0;
    end else begin
      dsp_core_clk_en_r <= slot_clk_en[`MPSC_SLOT_DSP_CORE];
      ethernet_mac_mem_clk_en_r <= slot_clk_en[`MPSC_SLOT_ETHERNET_MAC_MEM];
      ddr_ctrl_clk_en_r <= slot_clk_en[`MPSC_SLOT_DDR];
    end
  end

  // --------------------------------------------------------------------------
  // Slot status read
  // --------------------------------------------------------------------------
  logic rd_valid;
  logic busy_any;

  assign rd_valid = (slot_rd_idx < 6'(NS)) && !RSVD_MASK[slot_rd_idx];

  always_comb begin
    busy_any = 1'b0;
    for (int i = 0; i < NS; i++) begin
      if (slot_state[i] == MPSC_SLOT_STARTING || slot_state[i] == MPSC_SLOT_STOPPING)
        busy_any = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      slot_rd_enable_r <= 1'b0;
      slot_rd_state_r  <= MPSC_SLOT_OFF;
      slot_busy_r      <= 1'b0;
    end else begin
      slot_busy_r <= busy_any;
      if (rd_valid) begin
        slot_rd_enable_r <= slot_enable_r[slot_rd_idx];
        slot_rd_state_r  <= slot_state[slot_rd_idx];
      end else begin
        slot_rd_enable_r <= 1'b0;
        slot_rd_state_r  <= MPSC_SLOT_OFF;
      end
    end
  end

  // --------------------------------------------------------------------------
  // IO group power-down
  // --------------------------------------------------------------------------
  // Only buffer supply switches come from here; module clocks stay with slots
  always_ff @(posedge clock) begin
    if (rst) begin
      io_group_powerdown_r <= '0;
    end else if (io_group_wr) begin
      io_group_powerdown_r <= io_group_wdata;
    end
  end

  // --------------------------------------------------------------------------
  // Oscillator and PLL
  // --------------------------------------------------------------------------
  // Reset leaves the oscillator running and the multiplier at one, so the
  // device has a usable clock before software touches anything.
  always_ff @(posedge clock) begin
    if (rst) begin
      osc_en_r   <= `MPSC_OSC_EN_RST;
      pll_en_r   <= `MPSC_PLL_EN_RST;
      pll_mult_r <= `MPSC_PLL_MULT_X1;
    end else if (pll_ctl_wr) begin
      osc_en_r   <= pll_ctl_osc_en;
      pll_en_r   <= pll_ctl_pll_en;
      pll_mult_r <= pll_ctl_mult;
    end
  end

  // --------------------------------------------------------------------------
  // Video DACs
  // --------------------------------------------------------------------------
  logic                  video_encoder_enable_r;
  logic [VIDEO_DACS-1:0] dac_pwdn_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      video_encoder_enable_r <= 1'b0;
    end else if (video_encoder_mode_wr) begin
      video_encoder_enable_r <= video_encoder_mode_enable;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      dac_pwdn_r <= {VIDEO_DACS{1'b1}};
    end else if (dac_test_wr) begin
      dac_pwdn_r <= dac_test_pwdn;
    end
  end

  // A DAC runs only with the encoder on and its own power-down clear
  always_ff @(posedge clock) begin
    if (rst) begin
      video_dac_en_r <= '0;
    end else begin
      video_dac_en_r <= {VIDEO_DACS{video_encoder_enable_r}} & ~dac_pwdn_r;
    end
  end

  // --------------------------------------------------------------------------
  // DSP core and memory sleep
  // --------------------------------------------------------------------------
  // Wake beats an idle instruction in the same cycle so no wake is lost
  always_ff @(posedge clock) begin
    if (rst) begin
      dsp_core_sleep_r <= 1'b0;
    end else if (core_wake || !dsp_subsystem_power_on_r) begin
      dsp_core_sleep_r <= 1'b0;
    end else if (core_idle_instr) begin
      dsp_core_sleep_r <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      dsp_mem_sleep_r <= '0;
    end else if (core_mem_wr) begin
      dsp_mem_sleep_r <= core_mem_sleep;
    end
  end

  // --------------------------------------------------------------------------
  // DSP subsystem power
  // --------------------------------------------------------------------------
  // On the single-core variant the bit is fixed on and writes are dropped
  always_ff @(posedge clock) begin
    if (rst) begin
      dsp_subsystem_power_on_r <= `MPSC_DSP_PWR_ON_RST;
    end else if (DUAL_CORE && chip_sw_wr) begin
      dsp_subsystem_power_on_r <= chip_sw_dsp_power_on;
    end
  end

endmodule : mpsc_power_sleep_ctrl
